/* File: hwd_checker.sv */
`timescale 1ns/100ps
module hwd_checker import hwd_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic alert_n,
  input wire logic safe_monitoring_mode,
  input wire logic diag_active,
  input wire logic monitor_continue,
  input wire logic datapath_error
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc_w = psel && penable && pready && pwrite;
  wire cmd_rst = acc_w && paddr == CMD_OFF && pwdata[SOFTWARE_FULL_RESET_BIT];
  wire gen_w = acc_w && paddr == GEN_OFF;
  property p_safe_diag; $rose(safe_monitoring_mode) |-> ##[0:1] diag_active; endproperty
  a_safe_diag: assert property (p_safe_diag) else $error("diag not started");
  property p_diag_safe; diag_active |-> safe_monitoring_mode; endproperty
  a_diag_safe: assert property (p_diag_safe) else $error("diag outside safe mode");
  property p_rst_exit; cmd_rst |-> ##[1:2] !safe_monitoring_mode && !diag_active; endproperty
  a_rst_exit: assert property (p_rst_exit) else $error("safe mode kept after reset");
  property p_rst_hold; cmd_rst |=> ##1 !safe_monitoring_mode [*8]; endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("safe entry while disabled");
  property p_alert_hold; !alert_n && !(gen_w && pwdata[0]) && !cmd_rst |=> !alert_n; endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("alert released early");
  property p_cont; $rose(monitor_continue) |-> $past(diag_active) && safe_monitoring_mode; endproperty
  a_cont: assert property (p_cont) else $error("continue without open diag");
  property p_dp_mode; $rose(datapath_error) |-> !safe_monitoring_mode; endproperty
  a_dp_mode: assert property (p_dp_mode) else $error("check ran in safe mode");
  property p_dp_hold; datapath_error && !(gen_w && pwdata[1]) && !cmd_rst |=> datapath_error; endproperty
  a_dp_hold: assert property (p_dp_hold) else $error("path error lost");
  cover property ($rose(safe_monitoring_mode));
  cover property ($rose(monitor_continue));
  cover property ($rose(datapath_error));
endmodule // hwd_checker
bind hwd_top hwd_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .alert_n(alert_n), .safe_monitoring_mode(safe_monitoring_mode),
  .diag_active(diag_active), .monitor_continue(monitor_continue), .datapath_error(datapath_error));

/* File: hwd_host.sv */
`timescale 1ns/100ps
module hwd_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // Caller times key writes into the extended, closed or open window under test
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // hwd_host

/* File: hwd_pkg.sv */
package hwd_pkg;

  // Register byte offsets
  localparam logic [7:0] CFG1_OFF = 8'h00;
  localparam logic [7:0] CFG2_OFF = 8'h04;
  localparam logic [7:0] KEY_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0c;
  localparam logic [7:0] GEN_OFF = 8'h10;
  localparam logic [7:0] CMD_OFF = 8'h14;
  localparam logic [7:0] CNT_OFF = 8'h18;

  // Field positions
  localparam int DIV_LSB = 0;
  localparam int OPN_LSB = 8;
  localparam int CLO_LSB = 12;
  localparam int EXT_LSB = 16;
  localparam int DBNC_LSB = 0;
  localparam int EN_BIT = 4;
  localparam int SWW_BIT = 5;
  localparam int ALRTEN_BIT = 6;
  localparam int NO_MONITOR_SELECT_BIT = 7;
  localparam int SOFTWARE_FULL_RESET_BIT = 0;
  localparam int SLEEP_BIT = 1;
  localparam int VER_BIT = 2;
  localparam int WAKE_BIT = 3;

  // Reset values
  localparam logic [31:0] CFG1_RST = 32'h0000_0000;
  localparam logic [7:0] CFG2_RST = 8'h40;
  // Nonzero so the key sequence cannot lock at zero
  localparam logic [7:0] KEY_RST = 8'h5a;

  // Timing
  localparam int CLK_MHZ = 200;
  localparam int TICK_BASE_US = 256;
  localparam int TICK_BASE_CYC = TICK_BASE_US * CLK_MHZ;
  localparam int WIN_MULT = 8;
  localparam int RECOVERY_DELAY_US = 1000;
  localparam int RECOVERY_DELAY_CYC = RECOVERY_DELAY_US * CLK_MHZ;
  localparam int VERIFY_CYC = 64;

  typedef enum {MODE_CMD, MODE_SLEEP, MODE_SAFE} hwd_mode_t;
  typedef enum {WD_OFF, WD_EXT, WD_CLOSED, WD_OPEN} hwd_win_t;

  typedef struct packed {
    logic [2:0] initial_extension;
    logic [3:0] second_window_count;
    logic [3:0] first_window_count;
    logic [4:0] tick_divider;
  } hwd_cfg1_t;

  typedef struct packed {
    logic timeout_limit_error;
    logic expiry_error;
    logic early_key_error;
    logic bad_key_error;
  } hwd_status_t;

endpackage

/* File: hwd_top.sv */
// The APB register port and the register offsets were decided locally.
`timescale 1ns/100ps
// Contract
// - Each timeout increments violation counter, compared with a 1..120 threshold field.
// - Counter equal to threshold sets timeout-limit error and enters safe monitoring.
// - Sleep mode disables watchdog; no safe monitoring entry from it.
// - Enable clear or software reset keeps watchdog inactive, no safe entry.
// - Software reset in safe monitoring returns to commanded mode, registers defaulted.
// - Tick period is (divider plus one) times 256 us.
// - Closed window is tick times (first field plus one) times 8.
// - Open window ends after closed plus tick times (second field plus one) times 8.
// - First enable starts an extended window, extra length window end times (ext+1).
// - Valid refresh ends open window, starts closed window, updates key register in challenge mode.
// - Valid key in safe monitoring returns to commanded mode with extended window.
// - Violation counter clears on any valid refresh.
// - Challenge mode wrong key sets bad-key error.
// - Challenge mode key write in closed window sets early-key error.
// - Bad-key and early-key errors clear only when enable is written zero or on software reset.
// - Timeout safe entry starts watchdog/GPIO diagnostic; valid key write ends it.
// - Diagnostic unfinished at recovery delay continues per no-monitor select.
// - Verify trigger runs datapath check only in commanded mode; failure flags error.
// - Missing a valid key in the open window is a timeout.
// - Each timeout sets expiry error, cleared when enable written zero.
// - Simple window mode accepts any key value as valid refresh.
// - With alerts enabled, any watchdog error sets alert flag and pin until cleared.
module hwd_top #(
  parameter int TICK_BASE = hwd_pkg::TICK_BASE_CYC,
  parameter int RECOVERY_CYC = hwd_pkg::RECOVERY_DELAY_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic datapath_fault,
  output logic alert_n,
  output logic safe_monitoring_mode,
  output logic diag_active,
  output logic monitor_continue,
  output logic datapath_error
);
  import hwd_pkg::*;

  hwd_mode_t mode_reg;
  hwd_win_t win_reg;
  hwd_cfg1_t cfg1_reg;
  hwd_status_t st_reg;
  logic [7:0] cfg2_reg;
  logic [7:0] key_reg;
  logic [7:0] violation_counter_reg;
  logic [31:0] pre_reg;
  logic [15:0] tick_cnt_reg;
  logic [17:0] recov_cnt_reg;
  logic [6:0] ver_cnt_reg;
  logic watchdog_alert_flag_reg;
  logic ver_busy_reg;
  hwd_mode_t mode_next;
  hwd_cfg1_t cfg1_wdata;
  localparam hwd_cfg1_t CFG1_RST_F = {CFG1_RST[EXT_LSB +: 3], CFG1_RST[CLO_LSB +: 4], CFG1_RST[OPN_LSB +: 4],
    CFG1_RST[DIV_LSB +: 5]};

  // Bus decode
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd_hit = paddr == CFG1_OFF || paddr == CFG2_OFF || paddr == KEY_OFF || paddr == STATUS_OFF
    || paddr == GEN_OFF || paddr == CMD_OFF || paddr == CNT_OFF;
  wire wr_cfg1 = wr && paddr == CFG1_OFF;
  wire wr_cfg2 = wr && paddr == CFG2_OFF;
  wire wr_key = wr && paddr == KEY_OFF;
  wire wr_gen = wr && paddr == GEN_OFF;
  wire wr_cmd = wr && paddr == CMD_OFF;
  wire software_full_reset = wr_cmd && pwdata[SOFTWARE_FULL_RESET_BIT];
  wire sleep_req = wr_cmd && pwdata[SLEEP_BIT];
  wire wake_req = wr_cmd && pwdata[WAKE_BIT];
  wire ver_req = wr_cmd && pwdata[VER_BIT];
  assign cfg1_wdata = {pwdata[EXT_LSB +: 3], pwdata[CLO_LSB +: 4], pwdata[OPN_LSB +: 4], pwdata[DIV_LSB +: 5]};

  wire watchdog_enable_bit = cfg2_reg[EN_BIT];
  wire simple = cfg2_reg[SWW_BIT];
  wire [3:0] thr_field = cfg2_reg[DBNC_LSB +: 4];
  // Threshold is field times 8, with field zero meaning 1
  wire [7:0] threshold = (thr_field == 4'h0) ? 8'h01 : {1'b0, thr_field, 3'b000};
  wire wd_active = watchdog_enable_bit && mode_reg != MODE_SLEEP;

  // Window lengths in ticks
  wire [15:0] closed_ticks = 16'({4'h0, cfg1_reg.first_window_count} + 8'h01) * 16'(WIN_MULT);
  wire [15:0] open_ticks = 16'({4'h0, cfg1_reg.second_window_count} + 8'h01) * 16'(WIN_MULT);
  wire [15:0] end_ticks = closed_ticks + open_ticks;
  wire [15:0] ext_ticks = end_ticks + end_ticks * 16'({1'b0, cfg1_reg.initial_extension} + 4'h1);
  wire [31:0] tick_len = 32'({27'h0, cfg1_reg.tick_divider} + 32'h1) * 32'(TICK_BASE);
  wire tick = wd_active && pre_reg + 32'h1 >= tick_len;

  // Challenge key check: expected response is the next LFSR step of the key
  wire [7:0] expect_key = {key_reg[6:0], key_reg[7] ^ key_reg[5] ^ key_reg[4] ^ key_reg[3]};
  wire in_closed = win_reg == WD_CLOSED;
  wire key_match = pwdata[7:0] == expect_key;
  wire key_ok = simple || key_match;
  wire refresh = wd_active && wr_key && !(in_closed && !simple) && key_ok;
  wire bad_key = wd_active && wr_key && !simple && !key_match;
  wire early_key = wd_active && wr_key && !simple && in_closed;

  wire win_len_hit = tick && tick_cnt_reg + 16'h1 >= (win_reg == WD_EXT ? ext_ticks :
    win_reg == WD_CLOSED ? closed_ticks : open_ticks);
  wire timeout = win_len_hit && (win_reg == WD_OPEN || win_reg == WD_EXT) && !refresh;
  wire [7:0] cnt_inc = violation_counter_reg + 8'h1;
  wire limit_hit = timeout && cnt_inc == threshold && mode_reg == MODE_CMD;
  wire recov_done = diag_active && recov_cnt_reg + 18'h1 >= 18'(RECOVERY_CYC);
  wire any_err = |{st_reg, bad_key, early_key, timeout};
  wire alert_set = cfg2_reg[ALRTEN_BIT] && any_err;
  wire alert_clr = wr_gen && pwdata[0];
  wire watchdog_alert_flag_next = !software_full_reset && (alert_set || (watchdog_alert_flag_reg && !alert_clr));

  // Next-state logic
  hwd_win_t win_next;
  always_comb begin
    win_next = win_reg;
    if (!wd_active || software_full_reset) begin
      win_next = WD_OFF;
    end else if (win_reg == WD_OFF || (refresh && mode_reg == MODE_SAFE)) begin
      win_next = WD_EXT;
    end else if (refresh) begin
      win_next = WD_CLOSED;
    end else if (win_len_hit) begin
      win_next = (win_reg == WD_CLOSED) ? WD_OPEN : WD_CLOSED;
    end
  end

  always_comb begin
    mode_next = mode_reg;
    if (software_full_reset) begin
      mode_next = MODE_CMD;
    end else if (limit_hit) begin
      mode_next = MODE_SAFE;
    end else if (mode_reg == MODE_SAFE && refresh) begin
      mode_next = MODE_CMD;
    end else if (mode_reg == MODE_CMD && sleep_req) begin
      mode_next = MODE_SLEEP;
    end else if (mode_reg == MODE_SLEEP && wake_req) begin
      mode_next = MODE_CMD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg1_reg <= CFG1_RST_F;
      cfg2_reg <= CFG2_RST;
      key_reg <= KEY_RST;
      mode_reg <= MODE_CMD;
      win_reg <= WD_OFF;
      st_reg <= '0;
      violation_counter_reg <= 8'h00;
      pre_reg <= 32'h0;
      tick_cnt_reg <= 16'h0;
      watchdog_alert_flag_reg <= 1'b0;
    end else if (software_full_reset) begin
      cfg1_reg <= CFG1_RST_F;
      cfg2_reg <= CFG2_RST;
      key_reg <= KEY_RST;
      mode_reg <= MODE_CMD;
      win_reg <= WD_OFF;
      st_reg <= '0;
      violation_counter_reg <= 8'h00;
      pre_reg <= 32'h0;
      tick_cnt_reg <= 16'h0;
      watchdog_alert_flag_reg <= 1'b0;
    end else begin
      if (wr_cfg1) begin
        cfg1_reg <= cfg1_wdata;
      end
      if (wr_cfg2) begin
        cfg2_reg <= pwdata[7:0];
      end
      win_reg <= win_next;
      pre_reg <= (tick || !wd_active || refresh) ? 32'h0 : pre_reg + 32'h1;
      tick_cnt_reg <= (win_next != win_reg || refresh || !wd_active) ? 16'h0 :
        (tick ? tick_cnt_reg + 16'h1 : tick_cnt_reg);
      if (refresh) begin
        key_reg <= simple ? key_reg : pwdata[7:0];
      end
      if (refresh) begin
        violation_counter_reg <= 8'h00;
      end else if (timeout) begin
        violation_counter_reg <= cnt_inc;
      end
      if (wr_cfg2 && !pwdata[EN_BIT]) begin
        st_reg <= '0;
      end else begin
        if (bad_key) st_reg.bad_key_error <= 1'b1;
        if (early_key) st_reg.early_key_error <= 1'b1;
        if (timeout) st_reg.expiry_error <= 1'b1;
        if (limit_hit) st_reg.timeout_limit_error <= 1'b1;
      end
      watchdog_alert_flag_reg <= watchdog_alert_flag_next;
      mode_reg <= mode_next;
    end
  end

  // Watchdog/GPIO diagnostic and recovery delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_active <= 1'b0;
      recov_cnt_reg <= 18'h0;
      monitor_continue <= 1'b0;
    end else if (software_full_reset || (diag_active && wd_active && wr_key && key_ok)) begin
      diag_active <= 1'b0;
      recov_cnt_reg <= 18'h0;
      monitor_continue <= 1'b0;
    end else if (limit_hit) begin
      diag_active <= 1'b1;
      recov_cnt_reg <= 18'h0;
    end else if (recov_done) begin
      diag_active <= 1'b0;
      monitor_continue <= !cfg2_reg[NO_MONITOR_SELECT_BIT];
    end else if (diag_active) begin
      recov_cnt_reg <= recov_cnt_reg + 18'h1;
    end
  end

  // Datapath check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ver_busy_reg <= 1'b0;
      ver_cnt_reg <= 7'h0;
      datapath_error <= 1'b0;
    end else if (software_full_reset) begin
      ver_busy_reg <= 1'b0;
      ver_cnt_reg <= 7'h0;
      datapath_error <= 1'b0;
    end else if (ver_req && !ver_busy_reg && mode_reg == MODE_CMD) begin
      ver_busy_reg <= 1'b1;
      ver_cnt_reg <= 7'h0;
    end else if (ver_busy_reg) begin
      if (datapath_fault) datapath_error <= 1'b1;
      ver_cnt_reg <= ver_cnt_reg + 7'h1;
      if (ver_cnt_reg == 7'(VERIFY_CYC - 1)) ver_busy_reg <= 1'b0;
    end else if (wr_gen && pwdata[1]) begin
      datapath_error <= 1'b0;
    end
  end

  // Read mux and registered outputs
  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      CFG1_OFF: rd_mux = {13'h0, cfg1_reg.initial_extension, cfg1_reg.second_window_count,
        cfg1_reg.first_window_count, 3'h0, cfg1_reg.tick_divider};
      CFG2_OFF: rd_mux = {24'h0, cfg2_reg};
      KEY_OFF: rd_mux = {24'h0, key_reg};
      STATUS_OFF: rd_mux = {28'h0, st_reg};
      GEN_OFF: rd_mux = {27'h0, ver_busy_reg, diag_active, mode_reg == MODE_SAFE, datapath_error,
        watchdog_alert_flag_reg};
      CNT_OFF: rd_mux = {24'h0, violation_counter_reg};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      alert_n <= 1'b1;
      safe_monitoring_mode <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !rd_hit;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
      alert_n <= !watchdog_alert_flag_next;
      safe_monitoring_mode <= mode_next == MODE_SAFE;
    end
  end

endmodule // hwd_top

/* File: tb_hwd_top.sv */
`timescale 1ns/100ps
module tb_hwd_top;
  import hwd_pkg::*;
  logic pclk, presetn, datapath_fault, psel, penable, pwrite, pready, pslverr, e;
  logic alert_n, safe_monitoring_mode, diag_active, monitor_continue, datapath_error;
  logic [7:0] paddr, key;
  logic [31:0] pwdata, prdata, q;
  int mismatches = 0;
  int comparisons = 0;
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  hwd_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  hwd_top #(.TICK_BASE(4), .RECOVERY_CYC(50)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .datapath_fault(datapath_fault), .alert_n(alert_n), .safe_monitoring_mode(safe_monitoring_mode),
    .diag_active(diag_active), .monitor_continue(monitor_continue), .datapath_error(datapath_error));
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    host.xfer(1'b0, a, 32'h0000_0000, q, e);
    chk(q, x);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Safe, diag, alert_n, continue
  task automatic pins(input logic [3:0] x);
    #1;
    chk({28'h0, safe_monitoring_mode, diag_active, alert_n, monitor_continue}, {28'h0, x});
  endtask
  function automatic logic [7:0] nxt(input logic [7:0] k);
    return {k[6:0], k[7] ^ k[5] ^ k[4] ^ k[3]};
  endfunction
  task automatic conclude;
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
  initial begin
    presetn = 1'b0;
    datapath_fault = 1'b0;
    cyc(10);
    presetn <= 1'b1;
    rd(CFG1_OFF, CFG1_RST);
    rd(CFG2_OFF, {24'h0, CFG2_RST});
    host.xfer(1'b0, 8'h1c, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    wr(CFG2_OFF, 32'h70);
    cyc(90);
    wr(KEY_OFF, 32'ha5);
    cyc(40);
    wr(KEY_OFF, 32'h3c);
    rd(CNT_OFF, 32'h0);
    rd(STATUS_OFF, 32'h0);
    cyc(75);
    pins(4'b1100);
    rd(STATUS_OFF, 32'hc);
    wr(CMD_OFF, 32'h4);
    rd(GEN_OFF, 32'hd);
    wr(KEY_OFF, 32'h11);
    pins(4'b0000);
    wr(CFG2_OFF, 32'h40);
    rd(STATUS_OFF, 32'h0);
    wr(GEN_OFF, 32'h1);
    pins(4'b0010);
    wr(CFG2_OFF, 32'h50);
    host.xfer(1'b0, KEY_OFF, 32'h0, q, e);
    key = nxt(q[7:0]);
    wr(KEY_OFF, {24'h0, key});
    rd(KEY_OFF, {24'h0, key});
    wr(KEY_OFF, {24'h0, nxt(key)});
    cyc(30);
    wr(KEY_OFF, {24'h0, ~nxt(key)});
    rd(STATUS_OFF, 32'h3);
    wr(CFG2_OFF, 32'h40);
    rd(STATUS_OFF, 32'h0);
    wr(CFG2_OFF, 32'h70);
    cyc(200);
    #1;
    chk({30'h0, safe_monitoring_mode, monitor_continue}, 32'h3);
    wr(CMD_OFF, 32'h1);
    pins(4'b0010);
    rd(CFG2_OFF, 32'h40);
    cyc(300);
    pins(4'b0010);
    wr(CFG2_OFF, 32'h71);
    wr(CMD_OFF, 32'h2);
    cyc(300);
    pins(4'b0010);
    wr(CMD_OFF, 32'h8);
    cyc(200);
    host.xfer(1'b0, CNT_OFF, 32'h0, q, e);
    chk({30'h0, q > 0 && q < 8, safe_monitoring_mode}, 32'h2);
    wr(KEY_OFF, 32'h0);
    rd(CNT_OFF, 32'h0);
    wr(CFG2_OFF, 32'h40);
    wr(GEN_OFF, 32'h1);
    datapath_fault <= 1'b1;
    wr(CMD_OFF, 32'h4);
    cyc(100);
    rd(GEN_OFF, 32'h2);
    chk({31'h0, datapath_error}, 32'h1);
    wr(GEN_OFF, 32'h2);
    rd(GEN_OFF, 32'h0);
    conclude();
  end
endmodule // tb_hwd_top
